// ==== rtl/htgso_defs.svh ====
// Constants of the heat-transfer gauge status object: attribute ids,
// service codes, general status codes, field positions and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef HTGSO_DEFS_SVH
`define HTGSO_DEFS_SVH

// ****************************************************************
// Attribute identifiers
// ****************************************************************
`define HTGSO_ATTR_VALID      8'h05
`define HTGSO_ATTR_VALUE      8'h06
`define HTGSO_ATTR_SAFE_SEL   8'h19
`define HTGSO_ATTR_SAFE_VAL   8'h1a
`define HTGSO_ATTR_OVER       8'h20
`define HTGSO_ATTR_UNDER      8'h21
`define HTGSO_ATTR_WARN       8'h5e
`define HTGSO_ATTR_ALARM      8'h5f
`define HTGSO_ATTR_EXT        8'h60
`define HTGSO_ATTR_SUBCLASS   8'h63
`define HTGSO_ATTR_BRIDGE     8'h65
`define HTGSO_ATTR_ADJ        8'h66

// ****************************************************************
// Services and general status codes
// ****************************************************************
`define HTGSO_SVC_GET         8'h0e
`define HTGSO_SVC_SET         8'h10
`define HTGSO_GS_OK           8'h00
`define HTGSO_GS_BAD_SVC      8'h08
`define HTGSO_GS_BAD_VAL      8'h09
`define HTGSO_GS_NOT_SET      8'h0e
`define HTGSO_GS_NO_ATTR      8'h14

// ****************************************************************
// Field positions and fixed values
// ****************************************************************
`define HTGSO_EXT_INVALID     0
`define HTGSO_EXT_OVER        1
`define HTGSO_EXT_UNDER       2
`define HTGSO_ELEC_BIT        9
`define HTGSO_ELEMENT_BIT     0
`define HTGSO_SUBCLASS_HTVG   16'h0002
`define HTGSO_SAFE_SEL_MAX    8'h03
`define HTGSO_BRIDGE_SEL_MAX  8'h02

// ****************************************************************
// Reset values, limits and trip scale factors
// ****************************************************************
`define HTGSO_ZERO16          16'h0000
`define HTGSO_ZERO8           8'h00
`define HTGSO_INT_MAX         16'sh7fff
`define HTGSO_INT_MIN         16'sh8000
`define HTGSO_HV_STD_DEFAULT  16'sh0001
`define HTGSO_TRIP_MUL_VALUE  20'sh00005
`define HTGSO_TRIP_MUL_CEIL   20'sh00006

`endif

// ==== rtl/htgso_pkg.sv ====
// Types shared by the heat-transfer gauge status object.
// Assumes the constants header is on the include path.
`include "htgso_defs.svh"

package htgso_pkg;
  // Signed INT attribute value
  typedef logic signed [15:0] htgso_val_t;
  // Bridge power selector, codes 0, 1, 2 in this order
  typedef enum logic [1:0] {BRG_ALWAYS_ON, BRG_TRIP_OFF, BRG_ALWAYS_OFF} htgso_bridge_t;
  // Output substitution selector
  typedef enum logic [1:0] {SAFE_ZERO, SAFE_FULL, SAFE_HOLD, SAFE_VALUE} htgso_safe_t;
endpackage

// ==== rtl/htgso_range_cmp.sv ====
// Range comparator: checks one sample against the valid limits and the
// bridge trip level of 120 percent of the combined range ceiling.
// Assumes all operands are signed INT counts on one clock.
`include "htgso_defs.svh"

module htgso_range_cmp (
  input  wire htgso_pkg::htgso_val_t sample,        // Measured value
  input  wire htgso_pkg::htgso_val_t overLimit,     // Highest valid value
  input  wire htgso_pkg::htgso_val_t underLimit,    // Lowest valid value
  input  wire htgso_pkg::htgso_val_t rangeCeiling,  // Combined range ceiling
  output logic                       aboveOver,     // Sample above limit
  output logic                       belowUnder,    // Sample below limit
  output logic                       tripReached    // Sample at 120% ceiling
);
  import htgso_pkg::*;

  logic signed [19:0] sampleX5;   // Sample times five
  logic signed [19:0] ceilingX6;  // Ceiling times six

  // ****************************************************************
  // Comparisons
  // ****************************************************************
  // Scaled compare avoids a divider: v >= 1.2 c  <=>  5 v >= 6 c
  always_comb begin
    sampleX5    = 20'(20'(sample) * `HTGSO_TRIP_MUL_VALUE);
    ceilingX6   = 20'(20'(rangeCeiling) * `HTGSO_TRIP_MUL_CEIL);
    aboveOver   = sample > overLimit;
    belowUnder  = sample < underLimit;
    tripReached = sampleX5 >= ceilingX6;
  end
endmodule // htgso_range_cmp

// ==== rtl/htgso_top.sv ====
// Heat-transfer gauge status object: attribute get/set answering,
// range flags, status extension, warning and alarm words, output
// substitution and bridge power-off control.
// Assumes one 50 MHz clock, requests and samples synchronous to it.
`include "htgso_defs.svh"

module htgso_top #(
  parameter logic signed [15:0] OVER_LIMIT   = `HTGSO_INT_MAX,       // Highest valid value
  parameter logic signed [15:0] UNDER_LIMIT  = `HTGSO_INT_MIN,       // Lowest valid value
  parameter logic signed [15:0] HV_STD_LIMIT = `HTGSO_HV_STD_DEFAULT // 1E-4 mbar in counts
) (
  input  wire                        clock,            // 50 MHz clock
  input  wire                        nrst,             // Async reset, low
  input  wire                        reqValid,         // Request strobe
  input  wire  [7:0]                 reqService,       // Service code
  input  wire  [7:0]                 reqAttr,          // Attribute id
  input  wire  [15:0]                reqData,          // Set data
  input  wire                        sampleValid,      // New sample strobe
  input  wire htgso_pkg::htgso_val_t sampleValue,      // Measured value
  input  wire htgso_pkg::htgso_val_t rangeCeiling,     // Combined range ceiling
  input  wire                        executeState,     // Object in execute
  input  wire                        elecWarn,         // Electronics warning
  input  wire                        elementFail,      // Sensor element failure
  input  wire                        elecFail,         // Electronics failure
  output logic                       respValid_q,      // Answer strobe
  output logic [7:0]                 respStatus_q,     // General status
  output logic [15:0]                respData_q,       // Get data
  output logic                       bridgePowerOn_q,  // Bridge supply enable
  output htgso_pkg::htgso_val_t      outValue_q,       // Output value
  output logic                       readingValid_q,   // Valid flag
  output logic [7:0]                 statusExt_q,      // Status extension
  output logic                       adjStandard_q,    // Standard hv adjust
  output htgso_pkg::htgso_val_t      adjTarget_q       // Adjust target
);
  import htgso_pkg::*;
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [1:0]    rstSync_q;     // Reset release chain
  logic          rstN;          // Synchronised reset
  logic [7:0]    safeSel_q;     // Safe state selector
  htgso_val_t    safeVal_q;     // Safe value
  logic [7:0]    bridgeSel_q;   // Bridge selector
  logic          bridgeOff_q;   // Bridge switched off
  logic          overFlag_q;    // Last sample over limit
  logic          underFlag_q;   // Last sample under limit
  htgso_val_t    lastValue_q;   // Last sample
  logic [15:0]   warnWord_q;    // Warning word
  logic [15:0]   alarmWord_q;   // Alarm word
  logic          aboveOver, belowUnder, tripReached; // Comparator results
  logic          isSet;         // Set request this cycle
  logic [7:0]    setStatus;     // Set answer code
  logic          setOk;         // Set accepted
  logic [15:0]   getData;       // Get mux
  logic [7:0]    getStatus;     // Get answer code
  logic          substitute;    // Output substitution active
  // ****************************************************************
  // Reset release
  // ****************************************************************
  // Two flops so release never lands mid-setup
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];
  // ****************************************************************
  // Comparator
  // ****************************************************************
  htgso_range_cmp uCmp (
    .sample       (sampleValue),
    .overLimit    (OVER_LIMIT),
    .underLimit   (UNDER_LIMIT),
    .rangeCeiling (rangeCeiling),
    .aboveOver    (aboveOver),
    .belowUnder   (belowUnder),
    .tripReached  (tripReached)
  );
  // ****************************************************************
  // Set decode
  // ****************************************************************
  // Checks attribute writability and value range of a set
  function automatic logic [7:0] setCheck(input logic [7:0] attr, input logic [15:0] data);
    logic [7:0] code;
    code = `HTGSO_GS_OK;
    unique case (attr)
      `HTGSO_ATTR_SAFE_SEL: code = (data > 16'(`HTGSO_SAFE_SEL_MAX)) ?
                                   `HTGSO_GS_BAD_VAL : `HTGSO_GS_OK;
      `HTGSO_ATTR_BRIDGE:   code = (data > 16'(`HTGSO_BRIDGE_SEL_MAX)) ?
                                   `HTGSO_GS_BAD_VAL : `HTGSO_GS_OK;
      `HTGSO_ATTR_SAFE_VAL, `HTGSO_ATTR_ADJ: code = `HTGSO_GS_OK;
      `HTGSO_ATTR_VALID, `HTGSO_ATTR_VALUE, `HTGSO_ATTR_OVER, `HTGSO_ATTR_UNDER,
      `HTGSO_ATTR_WARN, `HTGSO_ATTR_ALARM, `HTGSO_ATTR_EXT,
      `HTGSO_ATTR_SUBCLASS: code = `HTGSO_GS_NOT_SET;
      default:              code = `HTGSO_GS_NO_ATTR;
    endcase
    return code;
  endfunction
  always_comb begin
    isSet     = reqValid && (reqService == `HTGSO_SVC_SET);
    setStatus = setCheck(reqAttr, reqData);
    setOk     = isSet && (setStatus == `HTGSO_GS_OK);
  end
  // ****************************************************************
  // Get multiplexer
  // ****************************************************************
  // Narrow attributes sit in the low bits, upper bits read zero
  always_comb begin
    getStatus = `HTGSO_GS_OK;
    getData   = `HTGSO_ZERO16;
    unique case (reqAttr)
      `HTGSO_ATTR_VALID:    getData = {15'h0000, readingValid_q};
      `HTGSO_ATTR_VALUE:    getData = outValue_q;
      `HTGSO_ATTR_SAFE_SEL: getData = {8'h00, safeSel_q};
      `HTGSO_ATTR_SAFE_VAL: getData = safeVal_q;
      `HTGSO_ATTR_OVER:     getData = OVER_LIMIT;
      `HTGSO_ATTR_UNDER:    getData = UNDER_LIMIT;
      `HTGSO_ATTR_WARN:     getData = warnWord_q;
      `HTGSO_ATTR_ALARM:    getData = alarmWord_q;
      `HTGSO_ATTR_EXT:      getData = {8'h00, statusExt_q};
      `HTGSO_ATTR_SUBCLASS: getData = `HTGSO_SUBCLASS_HTVG;
      `HTGSO_ATTR_BRIDGE:   getData = {8'h00, bridgeSel_q};
      `HTGSO_ATTR_ADJ:      getData = adjTarget_q;
      default:              getStatus = `HTGSO_GS_NO_ATTR;
    endcase
  end
  // ****************************************************************
  // Answer port
  // ****************************************************************
  // One answer per request, exactly one cycle later
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      respValid_q  <= 1'b0;
      respStatus_q <= `HTGSO_ZERO8;
      respData_q   <= `HTGSO_ZERO16;
    end else begin
      respValid_q <= reqValid;
      if (reqValid) begin
        respData_q <= `HTGSO_ZERO16;
        if (reqService == `HTGSO_SVC_GET) begin
          respStatus_q <= getStatus;
          respData_q   <= (getStatus == `HTGSO_GS_OK) ? getData : `HTGSO_ZERO16;
        end else if (reqService == `HTGSO_SVC_SET) begin
          respStatus_q <= setStatus;
        end else begin
          respStatus_q <= `HTGSO_GS_BAD_SVC;
        end
      end
    end
  end
  // ****************************************************************
  // Settable attributes
  // ****************************************************************
  // Held in flops; persistence across power loss is outside this block
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      safeSel_q   <= `HTGSO_ZERO8;
      safeVal_q   <= `HTGSO_ZERO16;
      bridgeSel_q <= `HTGSO_ZERO8;
      adjTarget_q <= `HTGSO_ZERO16;
    end else if (setOk) begin
      unique case (reqAttr)
        `HTGSO_ATTR_SAFE_SEL: safeSel_q   <= reqData[7:0];
        `HTGSO_ATTR_SAFE_VAL: safeVal_q   <= reqData;
        `HTGSO_ATTR_BRIDGE:   bridgeSel_q <= reqData[7:0];
        `HTGSO_ATTR_ADJ:      adjTarget_q <= reqData;
        default:              ;
      endcase
    end
  end
  // ****************************************************************
  // High vacuum adjustment select
  // ****************************************************************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      adjStandard_q <= 1'b1;
    end else begin
      adjStandard_q <= adjTarget_q < HV_STD_LIMIT;
    end
  end
  // ****************************************************************
  // Bridge power control
  // ****************************************************************
  // A trip latches: with the bridge unpowered no sample can undo it,
  // so only a new selector write re-arms the bridge
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      bridgeOff_q     <= 1'b0;
      bridgePowerOn_q <= 1'b0;
    end else begin
      bridgePowerOn_q <= !bridgeOff_q;
      if (setOk && reqAttr == `HTGSO_ATTR_BRIDGE) begin
        bridgeOff_q <= reqData[1:0] == 2'(BRG_ALWAYS_OFF);
      end else begin
        unique case (bridgeSel_q[1:0])
          2'(BRG_ALWAYS_ON):  bridgeOff_q <= 1'b0;
          2'(BRG_ALWAYS_OFF): bridgeOff_q <= 1'b1;
          2'(BRG_TRIP_OFF):   if (sampleValid && tripReached) begin
            bridgeOff_q <= 1'b1;
          end
          default:            bridgeOff_q <= 1'b0;
        endcase
      end
    end
  end
  // ****************************************************************
  // Sample capture
  // ****************************************************************
  // Flags follow each new sample only
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      overFlag_q  <= 1'b0;
      underFlag_q <= 1'b0;
      lastValue_q <= `HTGSO_ZERO16;
    end else if (sampleValid) begin
      overFlag_q  <= aboveOver;
      underFlag_q <= belowUnder;
      lastValue_q <= sampleValue;
    end
  end
  // ****************************************************************
  // Valid flag and status extension
  // ****************************************************************
  // Both from one expression so the invalid bit mirrors the flag exactly
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      readingValid_q <= 1'b1;  // Matches invalid bit 0 from the first edge
      statusExt_q    <= `HTGSO_ZERO8;
    end else begin
      readingValid_q <= !(overFlag_q || underFlag_q || bridgeOff_q);
      statusExt_q    <= `HTGSO_ZERO8;
      statusExt_q[`HTGSO_EXT_INVALID] <= overFlag_q || underFlag_q || bridgeOff_q;
      statusExt_q[`HTGSO_EXT_OVER]    <= overFlag_q;
      statusExt_q[`HTGSO_EXT_UNDER]   <= underFlag_q;
    end
  end
  // ****************************************************************
  // Warning and alarm words
  // ****************************************************************
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      warnWord_q  <= `HTGSO_ZERO16;
      alarmWord_q <= `HTGSO_ZERO16;
    end else begin
      warnWord_q  <= `HTGSO_ZERO16;
      warnWord_q[`HTGSO_ELEC_BIT]     <= elecWarn;
      alarmWord_q <= `HTGSO_ZERO16;
      alarmWord_q[`HTGSO_ELEMENT_BIT] <= elementFail;
      alarmWord_q[`HTGSO_ELEC_BIT]    <= elecFail;
    end
  end
  // ****************************************************************
  // Output value substitution
  // ****************************************************************
  // Off bridge or non-execute state both fall back to the safe behaviour
  assign substitute = bridgeOff_q || !executeState;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      outValue_q <= `HTGSO_ZERO16;
    end else if (substitute) begin
      unique case (safeSel_q)
        8'(SAFE_ZERO):  outValue_q <= `HTGSO_ZERO16;
        8'(SAFE_FULL):  outValue_q <= OVER_LIMIT;
        8'(SAFE_HOLD):  outValue_q <= outValue_q;
        8'(SAFE_VALUE): outValue_q <= safeVal_q;
        default:        outValue_q <= `HTGSO_ZERO16;
      endcase
    end else begin
      outValue_q <= lastValue_q;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);
  a_over_invalid:  assert property (overFlag_q |=> !readingValid_q)
    else $error("over-range did not clear valid");
  a_under_invalid: assert property (underFlag_q |=> !readingValid_q)
    else $error("under-range did not clear valid");
  a_sel_off:       assert property ((bridgeSel_q == 8'h02)[*3] |-> !bridgePowerOn_q)
    else $error("selector 2 left bridge powered");
  a_sel_on:        assert property ((bridgeSel_q == 8'h00)[*3] |-> bridgePowerOn_q)
    else $error("selector 0 left bridge unpowered");
  a_off_safe:      assert property (bridgeOff_q && safeSel_q == 8'h03
                                    |=> outValue_q == $past(safeVal_q))
    else $error("off bridge did not output safe value");
  a_off_invalid:   assert property (bridgeOff_q |=> statusExt_q[0])
    else $error("off bridge not reported invalid");
  a_adj_std:       assert property (adjTarget_q < HV_STD_LIMIT |=> adjStandard_q)
    else $error("low target did not pick standard adjust");
  a_exec_zero:     assert property (!executeState && safeSel_q == 8'h00
                                    |=> outValue_q == 16'h0000)
    else $error("safe state zero not applied");
  a_warn_bits:     assert property (warnWord_q == {6'h00, $past(elecWarn), 9'h000})
    else $error("warning word layout wrong");
  a_alarm_bits:    assert property (alarmWord_q ==
                     {6'h00, $past(elecFail), 8'h00, $past(elementFail)})
    else $error("alarm word layout wrong");
  a_ext_compl:     assert property (statusExt_q[0] == !readingValid_q
                                    && statusExt_q[7:3] == 5'h00)
    else $error("status extension disagrees with valid flag");
  a_sub_get:       assert property (reqValid && reqService == 8'h0e && reqAttr == 8'h63
                                    |=> respValid_q && respData_q == 16'h0002)
    else $error("subclass answer wrong");
  a_valid_flag:    assert property (!overFlag_q && !underFlag_q && !bridgeOff_q
                                    |=> readingValid_q)
    else $error("valid flag not set");
  a_resp_once:     assert property (respValid_q == $past(reqValid))
    else $error("answer not one cycle after request");
  a_sample_flag:   assert property (sampleValid && aboveOver |=> ##1 !readingValid_q)
    else $error("sample over limit not reflected");
  c_trip:   cover property (bridgeSel_q == 8'h01 && sampleValid && tripReached);
  c_set_ok: cover property (setOk ##1 respStatus_q == 8'h00);
  c_safe:   cover property (!executeState && safeSel_q == 8'h03);
  c_under:  cover property (underFlag_q ##1 statusExt_q[2]);
endmodule // htgso_top

// ==== tb/htgso_master.sv ====
// Fieldbus master model: issues single-attribute get and set requests.
// Assumes the device answers on the edge that takes a request.
module htgso_master (
  input  wire         clock,         // Shared clock
  input  wire         respValid_q,   // Answer strobe
  input  wire  [7:0]  respStatus_q,  // General status
  input  wire  [15:0] respData_q,    // Get data
  output logic        reqValid,      // Request strobe
  output logic [7:0]  reqService,    // Service code
  output logic [7:0]  reqAttr,       // Attribute id
  output logic [15:0] reqData        // Set data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Request driver
  // ****************************************************************
  initial begin
    reqValid = 1'b0;
    reqService = 8'h00;
    reqAttr = 8'h00;
    reqData = 16'h0000;
  end
  // One request, held until the taking edge, bounded answer wait
  task automatic xfer(input logic [7:0] svc, input logic [7:0] attr, input logic [15:0] data,
                      output logic [7:0] st, output logic [15:0] rd, output bit ok);
    int n;
    n = 0;
    @(posedge clock);
    reqValid <= 1'b1;
    reqService <= svc;
    reqAttr <= attr;
    reqData <= data;
    @(posedge clock);
    reqValid <= 1'b0;
    // Released lines must not keep showing the old request
    reqService <= ~svc;
    reqAttr <= ~attr;
    reqData <= ~data;
    #1;
    while (respValid_q !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    ok = (respValid_q === 1'b1);
    st = respStatus_q;
    rd = respData_q;
  endtask
endmodule // htgso_master

// ==== tb/tb_top.sv ====
// Testbench for the gauge status object: attribute access and sample flags.
// Assumes a 50 MHz clock and the master model driving the request port.
`include "htgso_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import htgso_pkg::*;
  // ****************************************************************
  // Signals, instances and tasks
  // ****************************************************************
  logic clock, nrst, reqValid, sampleValid, executeState, elecWarn, elementFail, elecFail;
  logic respValid_q, bridgePowerOn_q, readingValid_q, adjStandard_q;
  logic [7:0] reqService, reqAttr, respStatus_q, statusExt_q;
  logic [15:0] reqData, respData_q;
  htgso_val_t sampleValue, rangeCeiling, outValue_q, adjTarget_q;
  int nErrors, compares;
  localparam logic [7:0] G = `HTGSO_SVC_GET;
  localparam logic [7:0] S = `HTGSO_SVC_SET;
  // Narrow limits so both range edges are reachable
  htgso_top #(.OVER_LIMIT(16'sd1000), .UNDER_LIMIT(-16'sd1000), .HV_STD_LIMIT(16'sd100)) dut (
    .clock(clock), .nrst(nrst), .reqValid(reqValid), .reqService(reqService),
    .reqAttr(reqAttr), .reqData(reqData), .sampleValid(sampleValid),
    .sampleValue(sampleValue), .rangeCeiling(rangeCeiling), .executeState(executeState),
    .elecWarn(elecWarn), .elementFail(elementFail), .elecFail(elecFail),
    .respValid_q(respValid_q), .respStatus_q(respStatus_q), .respData_q(respData_q),
    .bridgePowerOn_q(bridgePowerOn_q), .outValue_q(outValue_q),
    .readingValid_q(readingValid_q), .statusExt_q(statusExt_q),
    .adjStandard_q(adjStandard_q), .adjTarget_q(adjTarget_q));
  htgso_master master (.clock(clock), .respValid_q(respValid_q), .respStatus_q(respStatus_q),
    .respData_q(respData_q), .reqValid(reqValid), .reqService(reqService),
    .reqAttr(reqAttr), .reqData(reqData));
  always #10 clock = ~clock;
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Access through the master, then compare status and data
  task automatic acc(logic [7:0] sv, logic [7:0] at, logic [15:0] d, logic [7:0] es,
                     logic [15:0] ed);
    logic [7:0] st;
    logic [15:0] rd;
    bit ok;
    master.xfer(sv, at, d, st, rd, ok);
    if (!ok) begin
      nErrors++;
      conclude();
    end else begin
      check("status", {8'h00, st}, {8'h00, es});
      check("data", rd, ed);
    end
  endtask
  // One sample pulse, then wait for the flags two edges later
  task automatic smp(htgso_val_t v);
    @(posedge clock);
    sampleValid <= 1'b1;
    sampleValue <= v;
    @(posedge clock);
    sampleValid <= 1'b0;
    sampleValue <= ~v;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    conclude();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {clock, nrst, sampleValid, elecWarn, elementFail, elecFail} = 6'h00;
    {nErrors, compares} = 0;
    executeState = 1'b1;
    sampleValue = 16'sd0;
    rangeCeiling = 16'sd100;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("valid", readingValid_q, 16'h0001);
    check("power", bridgePowerOn_q, 16'h0001);
    acc(G, 8'h63, 16'h0000, 8'h00, 16'h0002);
    acc(S, 8'h63, 16'h0005, 8'h0e, 16'h0000);
    acc(G, 8'h19, 16'h0000, 8'h00, 16'h0000);
    acc(G, 8'h1a, 16'h0000, 8'h00, 16'h0000);
    acc(G, 8'h20, 16'h0000, 8'h00, 16'h03e8);
    acc(G, 8'h21, 16'h0000, 8'h00, 16'hfc18);
    acc(8'h4b, 8'h63, 16'h0000, 8'h08, 16'h0000);
    acc(G, 8'h07, 16'h0000, 8'h14, 16'h0000);
    smp(16'sd1001);
    check("ext", statusExt_q, 16'h0003);
    check("valid", readingValid_q, 16'h0000);
    smp(16'sd1000);
    check("ext", statusExt_q, 16'h0000);
    smp(-16'sd1001);
    check("ext", statusExt_q, 16'h0005);
    acc(G, 8'h60, 16'h0000, 8'h00, 16'h0005);
    smp(-16'sd1000);
    check("valid", readingValid_q, 16'h0001);
    acc(G, 8'h05, 16'h0000, 8'h00, 16'h0001);
    // Safe state zero while out of execute
    executeState <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("out", outValue_q, 16'h0000);
    executeState <= 1'b1;
    elecWarn <= 1'b1;
    elementFail <= 1'b1;
    acc(G, 8'h5e, 16'h0000, 8'h00, 16'h0200);
    acc(G, 8'h5f, 16'h0000, 8'h00, 16'h0001);
    elecFail <= 1'b1;
    elementFail <= 1'b0;
    acc(G, 8'h5f, 16'h0000, 8'h00, 16'h0200);
    acc(S, 8'h1a, 16'h1234, 8'h00, 16'h0000);
    acc(S, 8'h19, 16'h0003, 8'h00, 16'h0000);
    acc(S, 8'h19, 16'h0004, 8'h09, 16'h0000);
    executeState <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("out", outValue_q, 16'h1234);
    executeState <= 1'b1;
    acc(S, 8'h65, 16'h0002, 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check("power", bridgePowerOn_q, 16'h0000);
    check("out", outValue_q, 16'h1234);
    smp(16'sd0);
    check("ext", statusExt_q, 16'h0001);
    acc(S, 8'h65, 16'h0003, 8'h09, 16'h0000);
    acc(S, 8'h65, 16'h0001, 8'h00, 16'h0000);
    smp(16'sd119);
    check("power", bridgePowerOn_q, 16'h0001);
    smp(16'sd120);
    check("power", bridgePowerOn_q, 16'h0000);
    acc(S, 8'h66, 16'h0032, 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check("std", adjStandard_q, 16'h0001);
    acc(S, 8'h66, 16'h0064, 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check("std", adjStandard_q, 16'h0000);
    check("target", adjTarget_q, 16'h0064);
    // Bridge still tripped: full scale, then hold keeps it
    acc(S, 8'h19, 16'h0001, 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check("out", outValue_q, 16'h03e8);
    acc(S, 8'h19, 16'h0002, 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    #1;
    check("out", outValue_q, 16'h03e8);
    conclude();
  end
endmodule // tb_top
